// >>> include/fbd_pkg.sv
// shared constants and types of the frame buffer span copy engine
package fbd_pkg;

  // register byte offsets on the apb slave
  localparam logic [7:0] FBD_OFF_CMD_STATUS = 8'h00;
  localparam logic [7:0] FBD_OFF_MODE_CONFIG = 8'h04;
  localparam logic [7:0] FBD_OFF_RASTER_OP = 8'h08;
  localparam logic [7:0] FBD_OFF_PIXEL_SHIFT = 8'h0c;
  localparam logic [7:0] FBD_OFF_DMA_BASE = 8'h10;
  localparam logic [7:0] FBD_OFF_AND_MASK = 8'h14;
  localparam logic [7:0] FBD_OFF_RED_VALUE = 8'h18;
  localparam logic [7:0] FBD_OFF_GREEN_VALUE = 8'h1c;

  // reset values
  localparam logic [31:0] FBD_RST_WORD = 32'h0000_0000;
  localparam logic [31:0] FBD_RST_AND_MASK = 32'hffff_ffff;

  // field positions
  localparam int FBD_BUSY_BIT = 0;
  localparam int FBD_MODE_MSB = 6;
  localparam int FBD_DST_BM_LSB = 8;
  localparam int FBD_SHIFT_MSB = 2;
  localparam int FBD_DITH_LSB = 27;
  localparam int FBD_CNT_LSB = 16;
  localparam int FBD_CNT_MSB = 26;
  localparam int FBD_ML_LSB = 8;
  localparam int FBD_MR_LSB = 0;

  // operating modes
  localparam logic [6:0] FBD_MODE_DMA_WRITE = 7'h07;
  localparam logic [6:0] FBD_MODE_DMA_READ_DITHER = 7'h17;
  localparam logic [6:0] FBD_MODE_DMA_READ_PLAIN = 7'h37;

  // destination bitmap code for the dual twelve bit format
  localparam logic [1:0] FBD_DST_BM_DUAL12 = 2'h2;

  // span geometry
  localparam int FBD_CNT_W = 12;
  localparam logic [31:0] FBD_QW_BYTES = 32'h0000_0008;
  localparam logic [31:0] FBD_DW_BYTES = 32'h0000_0004;

  // 4x4 ordered dither thresholds, row major
  localparam logic [63:0] FBD_DITHER_MAT = 64'h5d7f_193b_e4c6_a082;

  typedef enum logic [5:0] {
    FBD_S_IDLE = 6'b000001,
    FBD_S_WAIT = 6'b000010,
    FBD_S_ROT = 6'b000100,
    FBD_S_ARB = 6'b001000,
    FBD_S_LO = 6'b010000,
    FBD_S_HI = 6'b100000
  } fbd_state_t;

endpackage : fbd_pkg

// >>> core/fbd_rotator.sv
// residue register and byte rotator for the span copy engine
module fbd_rotator
  import fbd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic in_valid,
  input wire logic [63:0] quadin,
  input wire logic [2:0] shift,
  output logic out_valid,
  output logic [63:0] quadout
);

  typedef struct packed {
    logic [63:0] residue;
    logic valid;
    logic [63:0] quadout;
  } fbd_rot_state_t;

  fbd_rot_state_t q_r;
  fbd_rot_state_t q_nxt;
  logic [127:0] cat;

  always_comb begin
    q_nxt = q_r;
    q_nxt.valid = 1'b0;
    cat = {quadin, q_r.residue} >> {shift, 3'b000};
    if (clear) begin
      q_nxt.residue = 64'h0;
    end else if (in_valid) begin
      q_nxt.quadout = cat[63:0];
      q_nxt.residue = quadin;
      q_nxt.valid = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign out_valid = q_r.valid;
  assign quadout = q_r.quadout;

endmodule : fbd_rotator

// >>> core/fbd_span_copy.sv
// frame buffer to pci span copy engine with apb registers and read-path pixel conditioning
module fbd_span_copy
  import fbd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trig_valid,
  input wire logic [31:0] trig_addr,
  input wire logic [31:0] trig_data,
  output logic trig_ready,
  output logic fb_rd_req,
  output logic [31:0] fb_rd_addr,
  input wire logic fb_rd_valid,
  input wire logic [63:0] fb_rd_data,
  output logic pci_req,
  input wire logic pci_gnt,
  output logic mw_start,
  output logic mw_valid,
  output logic [31:0] mw_addr,
  output logic [31:0] mw_data,
  output logic [3:0] mw_be_n,
  output logic mw_last,
  input wire logic mw_ack,
  input wire logic mw_stop,
  input wire logic rd_src_valid,
  input wire logic [31:0] rd_src_data,
  output logic rd_dst_valid,
  output logic [31:0] rd_dst_data,
  output logic busy
);

  typedef struct packed {
    fbd_state_t st;
    logic busy;
    logic [31:0] mode_cfg;
    logic [31:0] raster_op;
    logic [31:0] pixel_shift;
    logic [31:0] dma_base;
    logic [31:0] and_mask;
    logic [31:0] red_value;
    logic [31:0] green_value;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic trig_ready;
    logic fb_req;
    logic [31:0] fb_addr;
    logic [FBD_CNT_W-1:0] rcnt;
    logic [1:0] idx;
    logic one;
    logic fin;
    logic [7:0] ml;
    logic [7:0] mr;
    logic [63:0] qo;
    logic do_lo;
    logic do_hi;
    logic [3:0] be_lo;
    logic [3:0] be_hi;
    logic [31:0] pci_addr;
    logic pci_req;
    logic owned;
    logic mw_start;
    logic mw_valid;
    logic [31:0] mw_addr;
    logic [31:0] mw_data;
    logic [3:0] mw_be_n;
    logic mw_last;
    logic rd_valid;
    logic [31:0] rd_data;
  } fbd_core_state_t;

  fbd_core_state_t q_r;
  fbd_core_state_t q_nxt;
  logic adv;
  logic rot_in_valid;
  logic rot_valid;
  logic [63:0] rot_out;
  logic [6:0] mode;
  logic [31:0] dith_word;
  logic [31:0] rep12_word;

  assign mode = q_r.mode_cfg[FBD_MODE_MSB:0];
  assign rot_in_valid = (q_r.st == FBD_S_WAIT) && fb_rd_valid;

  fbd_rotator u_rot (
    .pclk(pclk),
    .presetn(presetn),
    .clear(q_r.st == FBD_S_IDLE),
    .in_valid(rot_in_valid),
    .quadin(fb_rd_data),
    .shift(q_r.pixel_shift[FBD_SHIFT_MSB:0]),
    .out_valid(rot_valid),
    .quadout(rot_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read-path pixel conditioning

  function automatic logic [7:0] sat_add(input logic [7:0] v, input logic [3:0] t);
    logic [8:0] s;
    s = {1'b0, v} + {5'h00, t};
    sat_add = s[8] ? 8'hff : s[7:0];
  endfunction : sat_add

  logic [3:0] dith_idx;
  logic [3:0] dith_t;
  logic [7:0] dith_px;
  logic [31:0] rd_pre;

  always_comb begin
    dith_idx = {q_r.red_value[FBD_DITH_LSB+1:FBD_DITH_LSB],
                q_r.green_value[FBD_DITH_LSB+1:FBD_DITH_LSB]};
    dith_t = FBD_DITHER_MAT[{dith_idx, 2'b00} +: 4];
    dith_px = (sat_add(rd_src_data[23:16], dith_t) & 8'he0) |
              ((sat_add(rd_src_data[15:8], dith_t) >> 3) & 8'h1c) |
              (sat_add(rd_src_data[7:0], dith_t) >> 6);
    dith_word = {4{dith_px}};
    rd_pre = (mode == FBD_MODE_DMA_READ_DITHER) ? dith_word : rd_src_data;
  end

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_rep12
      assign rep12_word[gb*8 +: 8] = {rd_pre[gb*8+4 +: 4], rd_pre[gb*8+4 +: 4]};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    q_nxt = q_r;
    adv = 1'b0;
    q_nxt.fb_req = 1'b0;
    q_nxt.mw_start = 1'b0;
    q_nxt.rd_valid = 1'b0;
    q_nxt.pready = 1'b0;
    q_nxt.pslverr = 1'b0;

    // apb: answer one cycle after setup
    if (psel && !penable) begin
      q_nxt.pready = 1'b1;
      q_nxt.prdata = FBD_RST_WORD;
      case (paddr)
        FBD_OFF_CMD_STATUS: q_nxt.prdata[FBD_BUSY_BIT] = q_r.busy;
        FBD_OFF_MODE_CONFIG: q_nxt.prdata = q_r.mode_cfg;
        FBD_OFF_RASTER_OP: q_nxt.prdata = q_r.raster_op;
        FBD_OFF_PIXEL_SHIFT: q_nxt.prdata = q_r.pixel_shift;
        FBD_OFF_DMA_BASE: q_nxt.prdata = q_r.dma_base;
        FBD_OFF_AND_MASK: q_nxt.prdata = q_r.and_mask;
        FBD_OFF_RED_VALUE: q_nxt.prdata = q_r.red_value;
        FBD_OFF_GREEN_VALUE: q_nxt.prdata = q_r.green_value;
        default: q_nxt.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && q_r.pready && pwrite && !q_r.pslverr) begin
      case (paddr)
        FBD_OFF_MODE_CONFIG: q_nxt.mode_cfg = pwdata;
        FBD_OFF_RASTER_OP: q_nxt.raster_op = pwdata;
        FBD_OFF_PIXEL_SHIFT: q_nxt.pixel_shift = pwdata;
        FBD_OFF_DMA_BASE: q_nxt.dma_base = pwdata;
        FBD_OFF_AND_MASK: q_nxt.and_mask = pwdata;
        FBD_OFF_RED_VALUE: q_nxt.red_value = pwdata;
        FBD_OFF_GREEN_VALUE: q_nxt.green_value = pwdata;
        default: q_nxt.prdata = q_r.prdata;
      endcase
    end

    // read copy path, one conditioned dword per source dword
    if (rd_src_valid && (mode == FBD_MODE_DMA_READ_DITHER ||
        mode == FBD_MODE_DMA_READ_PLAIN)) begin
      q_nxt.rd_valid = 1'b1;
      if (q_r.raster_op[FBD_DST_BM_LSB+1:FBD_DST_BM_LSB] == FBD_DST_BM_DUAL12) begin
        q_nxt.rd_data = rep12_word;
      end else begin
        q_nxt.rd_data = rd_pre;
      end
    end

    // span sequencer
    unique case (q_r.st)
      FBD_S_IDLE: begin
        if (trig_valid && q_r.trig_ready) begin
          q_nxt.busy = 1'b1;
          q_nxt.fb_req = 1'b1;
          q_nxt.fb_addr = trig_addr;
          q_nxt.rcnt = {1'b0, trig_data[FBD_CNT_MSB:FBD_CNT_LSB]} + 12'h001;
          q_nxt.one = (trig_data[FBD_CNT_MSB:FBD_CNT_LSB] == 11'h000);
          q_nxt.ml = trig_data[FBD_ML_LSB +: 8];
          q_nxt.mr = trig_data[FBD_MR_LSB +: 8];
          q_nxt.pci_addr = q_r.dma_base;
          q_nxt.idx = 2'h0;
          q_nxt.st = FBD_S_WAIT;
        end
      end
      FBD_S_WAIT: begin
        if (fb_rd_valid) begin
          q_nxt.rcnt = q_r.rcnt - 12'h001;
          q_nxt.fb_addr = q_r.fb_addr + FBD_QW_BYTES;
          q_nxt.st = FBD_S_ROT;
        end
      end
      FBD_S_ROT: begin
        if (rot_valid) begin
          q_nxt.qo = rot_out;
          q_nxt.fin = (q_r.rcnt == '0);
          q_nxt.do_lo = 1'b1;
          q_nxt.do_hi = 1'b1;
          q_nxt.be_lo = 4'h0;
          q_nxt.be_hi = 4'h0;
          if (q_r.idx != 2'h2) begin
            q_nxt.idx = q_r.idx + 2'h1;
          end
          if (q_r.one) begin
            q_nxt.do_lo = 1'b1;
          end else if (q_r.idx == 2'h0) begin
            q_nxt.do_lo = 1'b0;
            q_nxt.do_hi = 1'b0;
          end else if (q_r.idx == 2'h1) begin
            q_nxt.do_lo = (q_r.ml[3:0] == 4'h0);
            q_nxt.be_lo = q_r.ml[3:0];
            q_nxt.be_hi = q_r.ml[7:4];
          end else if (q_r.rcnt == '0) begin
            q_nxt.be_lo = q_r.mr[3:0];
            q_nxt.be_hi = q_r.mr[7:4];
            q_nxt.do_hi = (q_r.mr[7:4] != 4'h0);
          end
          if (!q_nxt.do_lo && !q_nxt.do_hi) begin
            adv = 1'b1;
          end else if (q_r.owned) begin
            q_nxt.st = q_nxt.do_lo ? FBD_S_LO : FBD_S_HI;
          end else begin
            q_nxt.st = FBD_S_ARB;
          end
        end
      end
      FBD_S_ARB: begin
        q_nxt.pci_req = 1'b1;
        if (q_r.pci_req && pci_gnt) begin
          q_nxt.owned = 1'b1;
          q_nxt.mw_start = 1'b1;
          q_nxt.st = q_r.do_lo ? FBD_S_LO : FBD_S_HI;
        end
      end
      FBD_S_LO, FBD_S_HI: begin
        if (mw_ack) begin
          q_nxt.pci_addr = q_r.pci_addr + FBD_DW_BYTES;
          if (q_r.st == FBD_S_LO) begin
            q_nxt.do_lo = 1'b0;
            if (q_r.do_hi) begin
              q_nxt.st = FBD_S_HI;
            end else begin
              adv = 1'b1;
            end
          end else begin
            q_nxt.do_hi = 1'b0;
            adv = 1'b1;
          end
        end
        if (mw_stop) begin
          q_nxt.pci_req = 1'b0;
          q_nxt.owned = 1'b0;
          if (!adv) begin
            q_nxt.st = FBD_S_ARB;
          end
        end
      end
      default: q_nxt.st = FBD_S_IDLE;
    endcase

    if (adv) begin
      if (q_nxt.fin) begin
        q_nxt.busy = 1'b0;
        q_nxt.pci_req = 1'b0;
        q_nxt.owned = 1'b0;
        q_nxt.st = FBD_S_IDLE;
      end else begin
        q_nxt.fb_req = 1'b1;
        q_nxt.st = FBD_S_WAIT;
      end
    end

    q_nxt.trig_ready = (q_nxt.st == FBD_S_IDLE) &&
                       (q_nxt.mode_cfg[FBD_MODE_MSB:0] == FBD_MODE_DMA_WRITE);

    // pci dword presented from the next state; and_mask is applied, no rop
    q_nxt.mw_valid = (q_nxt.st == FBD_S_LO) || (q_nxt.st == FBD_S_HI);
    q_nxt.mw_addr = q_nxt.pci_addr;
    if (q_nxt.st == FBD_S_LO) begin
      q_nxt.mw_data = q_nxt.qo[31:0] & q_nxt.and_mask;
      q_nxt.mw_be_n = q_nxt.be_lo;
    end else begin
      q_nxt.mw_data = q_nxt.qo[63:32] & q_nxt.and_mask;
      q_nxt.mw_be_n = q_nxt.be_hi;
    end
    q_nxt.mw_last = q_nxt.mw_valid && q_nxt.fin &&
                    ((q_nxt.st == FBD_S_HI) || !q_nxt.do_hi);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
      q_r.st <= FBD_S_IDLE;
      q_r.and_mask <= FBD_RST_AND_MASK;
    end else begin
      q_r <= q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = q_r.prdata;
  assign pready = q_r.pready;
  assign pslverr = q_r.pslverr;
  assign trig_ready = q_r.trig_ready;
  assign fb_rd_req = q_r.fb_req;
  assign fb_rd_addr = q_r.fb_addr;
  assign pci_req = q_r.pci_req;
  assign mw_start = q_r.mw_start;
  assign mw_valid = q_r.mw_valid;
  assign mw_addr = q_r.mw_addr;
  assign mw_data = q_r.mw_data;
  assign mw_be_n = q_r.mw_be_n;
  assign mw_last = q_r.mw_last;
  assign rd_dst_valid = q_r.rd_valid;
  assign rd_dst_data = q_r.rd_data;
  assign busy = q_r.busy;

endmodule : fbd_span_copy

// >>> dv/fbd_span_copy_asserts.sv
// concurrent checks on the span copy engine ports
module fbd_span_copy_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic trig_valid,
  input wire logic trig_ready,
  input wire logic fb_rd_req,
  input wire logic [31:0] fb_rd_addr,
  input wire logic pci_req,
  input wire logic mw_start,
  input wire logic mw_valid,
  input wire logic [31:0] mw_addr,
  input wire logic mw_last,
  input wire logic mw_ack,
  input wire logic mw_stop,
  input wire logic rd_src_valid,
  input wire logic rd_dst_valid,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] rda_r, mwa_r;
  logic rds_r, mws_r;
  ////////////////////////////////////////////////////////////
  // last read address and next expected pci address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rds_r <= 1'b0;
      mws_r <= 1'b0;
      rda_r <= '0;
      mwa_r <= '0;
    end else begin
      if (fb_rd_req) rda_r <= fb_rd_addr;
      if (mw_valid && mw_ack) mwa_r <= mw_addr + 32'h4;
      rds_r <= busy && (rds_r || fb_rd_req);
      mws_r <= busy && (mws_r || (mw_valid && mw_ack));
    end
  end
  ////////////////////////////////////////////////////////////
  property p_apb; psel && !penable |=> pready ##1 !pready; endproperty
  a_apb: assert property (p_apb) else $error("apb answer late");
  property p_trig; trig_valid && trig_ready |=> busy && fb_rd_req && !trig_ready; endproperty
  a_trig: assert property (p_trig) else $error("trigger not taken");
  property p_fwd; fb_rd_req && rds_r |-> fb_rd_addr == rda_r + 32'h8; endproperty
  a_fwd: assert property (p_fwd) else $error("read address not forward");
  property p_one; fb_rd_req |=> !fb_rd_req; endproperty
  a_one: assert property (p_one) else $error("read request not a pulse");
  property p_hold; mw_valid && !mw_ack && !mw_stop |=> mw_valid && $stable(mw_addr); endproperty
  a_hold: assert property (p_hold) else $error("dword dropped");
  property p_track; mw_valid && mws_r |-> mw_addr == mwa_r; endproperty
  a_track: assert property (p_track) else $error("pci address off");
  property p_rearb; mw_valid && mw_stop && !mw_ack |=> ##[0:3] !pci_req; endproperty
  a_rearb: assert property (p_rearb) else $error("no re-arbitration");
  property p_done; mw_valid && mw_ack && mw_last |=> !busy; endproperty
  a_done: assert property (p_done) else $error("busy after last dword");
  property p_start; mw_start |-> mw_valid && pci_req; endproperty
  a_start: assert property (p_start) else $error("burst without bus");
  property p_rdp; rd_dst_valid |-> $past(rd_src_valid); endproperty
  a_rdp: assert property (p_rdp) else $error("stray read path output");
endmodule : fbd_span_copy_asserts

bind fbd_span_copy fbd_span_copy_asserts u_chk (.*);

// >>> dv/fbd_far_model.sv
// frame buffer memory and pci target beside the span copy engine
module fbd_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic stop_en,
  input wire logic fb_rd_req,
  input wire logic [31:0] fb_rd_addr,
  output logic fb_rd_valid,
  output logic [63:0] fb_rd_data,
  input wire logic pci_req,
  output logic pci_gnt,
  input wire logic mw_valid,
  output logic mw_ack,
  output logic mw_stop
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] a_r;
  logic [2:0] cnt_r;
  logic [3:0] ndw_r;
  logic stopped_r, tick_r, hit;
  function automatic logic [63:0] fbq(input logic [31:0] a);
    return {a ^ 32'h3c5a_0f96, a + 32'h0123_4567};
  endfunction : fbq
  // one burst termination per span, on the second dword
  assign hit = mw_valid && pci_gnt && stop_en && !stopped_r && ndw_r == 4'h1;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {a_r, cnt_r, ndw_r, stopped_r, tick_r} <= '0;
      {fb_rd_valid, fb_rd_data, pci_gnt, mw_ack, mw_stop} <= '0;
    end else begin
      tick_r <= !tick_r;
      pci_gnt <= pci_req;
      fb_rd_valid <= cnt_r == 3'h1;
      // idle data bus never repeats the last word
      fb_rd_data <= (cnt_r == 3'h1) ? fbq(a_r) : ~fb_rd_data;
      if (fb_rd_req) begin
        a_r <= fb_rd_addr;
        cnt_r <= slow ? 3'h4 : 3'h1;
      end else if (cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end
      mw_stop <= hit;
      mw_ack <= mw_valid && pci_gnt && !mw_ack && !mw_stop && !hit && (!slow || tick_r);
      if (hit) stopped_r <= 1'b1;
      if (!stop_en || (fb_rd_req && !pci_req)) stopped_r <= 1'b0;
      if (!pci_req) ndw_r <= 4'h0;
      else if (mw_valid && mw_ack) ndw_r <= ndw_r + 4'h1;
    end
  end
endmodule : fbd_far_model

// >>> dv/tb.sv
// self-checking bench of the span copy engine
module tb
  import fbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e_v;
  logic trig_valid = 0, rd_src_valid = 0, slow = 0, stop_en = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, trig_addr = '0, trig_data = '0, rd_src_data = '0, r_v;
  logic [31:0] prdata, fb_rd_addr, mw_addr, mw_data, rd_dst_data;
  logic pready, pslverr, trig_ready, fb_rd_req, fb_rd_valid, pci_req, pci_gnt;
  logic mw_start, mw_valid, mw_last, mw_ack, mw_stop, rd_dst_valid, busy;
  logic [3:0] mw_be_n;
  logic [63:0] fb_rd_data;
  logic [68:0] got_q[$], exp_q[$];
  logic [6:0] md[3] = '{FBD_MODE_DMA_WRITE, FBD_MODE_DMA_READ_DITHER, FBD_MODE_DMA_READ_PLAIN};
  int bad_count = 0, checks_done = 0, nrd = 0, seed = 32'h1d8b;
  fbd_span_copy dut (.*);
  fbd_far_model far (.*);
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (mw_valid && mw_ack) got_q.push_back({mw_addr, mw_data, mw_be_n, mw_last});
  always @(posedge pclk) if (fb_rd_req) nrd++;
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [68:0] s, e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r_v = prdata;
    e_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk("rdata", r_v, e);
    chk("pslverr", e_v, ee);
  endtask : rdc
  function automatic void put(input logic [31:0] b, d, am, input logic [3:0] be);
    exp_q.push_back({b + 32'(4 * exp_q.size()), d & am, be, 1'b0});
  endfunction : put
  // dithered 3:3:2 pixel, then high nibbles copied for the 12-bpp destination
  function automatic logic [31:0] dth(input logic [23:0] s, input logic [3:0] t);
    logic [8:0] r, g, b;
    logic [7:0] p;
    r = {1'b0, s[23:16]} + {5'h00, t};
    g = {1'b0, s[15:8]} + {5'h00, t};
    b = {1'b0, s[7:0]} + {5'h00, t};
    p = {r[8] ? 3'h7 : r[7:5], g[8] ? 3'h7 : g[7:5], b[8] ? 2'h3 : b[7:6]};
    return {4{p[7:4], p[7:4]}};
  endfunction : dth
  function automatic logic [23:0] rep12(input logic [23:0] s);
    return {s[23:20], s[23:20], s[15:12], s[15:12], s[7:4], s[7:4]};
  endfunction : rep12
  ////////////////////////////////////////////////////////////
  task automatic span(input int n, input logic [7:0] ml, mr, input logic [2:0] sh,
                      input logic [31:0] am, input logic sl, st);
    logic [63:0] q, o, res;
    logic [31:0] src, base;
    logic [68:0] lst;
    src = {$random(seed)} & 32'h00ff_fff8;
    base = {$random(seed)} & 32'hffff_fffc;
    slow <= sl;
    stop_en <= st;
    apb(1'b1, FBD_OFF_PIXEL_SHIFT, {29'h0, sh});
    apb(1'b1, FBD_OFF_DMA_BASE, base);
    apb(1'b1, FBD_OFF_AND_MASK, am);
    res = '0;
    exp_q.delete();
    got_q.delete();
    nrd = 0;
    for (int i = 0; i < n; i++) begin
      q = far.fbq(src + 32'(8 * i));
      o = 64'({q, res} >> (sh * 8));
      res = q;
      if (n == 1) begin
        put(base, o[31:0], am, 4'h0);
        put(base, o[63:32], am, 4'h0);
      end else if (i == 1) begin
        if (ml[3:0] == 4'h0) put(base, o[31:0], am, ml[3:0]);
        put(base, o[63:32], am, ml[7:4]);
      end else if (i == n - 1) begin
        put(base, o[31:0], am, mr[3:0]);
        if (mr[7:4] != 4'h0) put(base, o[63:32], am, mr[7:4]);
      end else if (i > 0) begin
        put(base, o[31:0], am, 4'h0);
        put(base, o[63:32], am, 4'h0);
      end
    end
    lst = exp_q.pop_back();
    exp_q.push_back(lst | 69'h1);
    trig_addr <= src;
    trig_data <= {5'h15, 11'(n - 1), ml, mr};
    trig_valid <= 1'b1;
    do @(posedge pclk); while (trig_ready !== 1'b1);
    trig_valid <= 1'b0;
    rdc(FBD_OFF_CMD_STATUS, 32'h1, 1'b0);
    for (int k = 0; k < 40000 && busy !== 1'b0; k++) @(posedge pclk);
    chk("reads", nrd, n);
    chk("dwords", got_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < got_q.size()) chk("dword", got_q[i], exp_q[i]);
  endtask : span
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) rdc(8'(4 * i), (i == 5) ? FBD_RST_AND_MASK : FBD_RST_WORD, 1'b0);
    rdc(8'h20, 32'h0, 1'b1);
    apb(1'b1, FBD_OFF_CMD_STATUS, 32'hffff_ffff);
    rdc(FBD_OFF_CMD_STATUS, 32'h0, 1'b0);
    trig_valid <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("busy", busy, 1'b0);
    trig_valid <= 1'b0;
    apb(1'b1, FBD_OFF_MODE_CONFIG, 32'(FBD_MODE_DMA_WRITE));
    rdc(FBD_OFF_MODE_CONFIG, 32'(FBD_MODE_DMA_WRITE), 1'b0);
    span(1, 8'hff, 8'hff, 3'h2, 32'hffff_ffff, 1'b0, 1'b0);
    span(2, 8'h0f, 8'hcc, 3'h3, 32'h00f0_f0f0, 1'b1, 1'b0);
    span(3, 8'h00, 8'h11, 3'h5, 32'hffff_ffff, 1'b0, 1'b1);
    span(4, 8'hf0, 8'h03, 3'h7, 32'hff00_ffff, 1'b1, 1'b1);
    span(2048, 8'h00, 8'hff, 3'h1, 32'hffff_ffff, 1'b0, 1'b1);
    repeat (12) span(1 + int'({$random(seed)} % 9), 8'($random(seed)), 8'($random(seed)),
                     3'($random(seed)), $random(seed), 1'($random(seed)), 1'($random(seed)));
    apb(1'b1, FBD_OFF_RASTER_OP, 32'h0000_0200);
    // dither row 3, column 1
    apb(1'b1, FBD_OFF_RED_VALUE, 32'h1800_0000);
    apb(1'b1, FBD_OFF_GREEN_VALUE, 32'h0800_0000);
    foreach (md[i]) begin
      apb(1'b1, FBD_OFF_MODE_CONFIG, 32'(md[i]));
      rd_src_data <= $random(seed);
      rd_src_valid <= 1'b1;
      @(posedge pclk);
      rd_src_valid <= 1'b0;
      @(posedge pclk);
      chk("dst valid", rd_dst_valid, i != 0);
      if (i == 2) chk("dst data", rd_dst_data[23:0], rep12(rd_src_data[23:0]));
      if (i == 1) chk("dither", rd_dst_data, dth(rd_src_data[23:0], FBD_DITHER_MAT[55:52]));
    end
    end_sim();
  end
  initial begin
    #900000;
    bad_count++;
    end_sim();
  end
endmodule : tb
